// file: mibcr_regs.svh
// Purpose: offsets, field positions and reset values of the statistics readout
// Assumes: byte-wide management register port, register numbers are decimal
// Notes:   definitions only
`ifndef MIBCR_REGS_SVH
`define MIBCR_REGS_SVH

// Indirect access registers (decimal register numbers)
`define MIBCR_REG_TABLE_SEL   8'd110
`define MIBCR_REG_TRIGGER     8'd111
`define MIBCR_REG_DATA_B3     8'd117
`define MIBCR_REG_DATA_B2     8'd118
`define MIBCR_REG_DATA_B1     8'd119
`define MIBCR_REG_DATA_B0     8'd120

// Table select codes
`define MIBCR_TBL_PORT_STAT   8'h1c
`define MIBCR_TBL_DROPPED     8'h1d

// Per-port table layout
`define MIBCR_PORT_STRIDE     9'h020
`define MIBCR_PORT_LAST_BASE  9'h080
`define MIBCR_CNT_PER_PORT    34
`define MIBCR_PORTS           5

// Dropped-frame table offsets
`define MIBCR_DROP_TX_BASE    9'h100
`define MIBCR_DROP_RX_BASE    9'h105
`define MIBCR_DROP_LAST       9'h109

// Statistics word fields
`define MIBCR_BIT_OVERFLOW    31
`define MIBCR_BIT_VALID       30
`define MIBCR_CNT_MSB         29
`define MIBCR_DROP_MSB        15
`define MIBCR_WORD_RESET      32'h0000_0000

`endif

// file: mibcr_pkg.sv
// Purpose: types shared by the statistics readout
// Assumes: nothing
// Notes:   constants live in mibcr_regs.svh
package mibcr_pkg;
	// Result of the last trigger decode
	typedef enum {MIBCR_SRC_NONE, MIBCR_SRC_PORT, MIBCR_SRC_DROP} mibcr_src_t;
endpackage

// file: mibcr_counter_readout.sv
// Purpose: per-port read-clear statistics and dropped-frame counters, indirect readout
// Assumes: event strobes are one-cycle pulses on clk; host bus is byte wide, one clock
// Notes:   counters live here; the frame datapaths only pulse the event inputs
//
// Summary of operation
// R1 - 32-bit word: overflow, valid, 30-bit count
// R2 - Tx drop counters at offsets 0x100-0x104
// R3 - Rx drop counters at offsets 0x105-0x109
// R4 - Drop word: 16-bit count, upper bits reserved
// R5 - Drop counters carry no overflow or valid
// R6 - Thirty-four statistics counters per port
// R7 - Write 0x1c to register 110 first
// R8 - Write offset to register 111 starts read
// R9 - Offset is port base plus counter index; counters 32-33 of each port are packed at 0xa0-0xa9 instead
// R10 - Result bytes in registers 117-120, MSB first
// R11 - Host rereads while valid bit clear
// R12 - Host treats bit 31 as overflow
// R13 - Select 0x1d for drop counters, read 119-120
// R14 - Per-port counters clear when read
// R15 - Drop counters keep value when read
// R16 - Host reads all counters every 30 seconds
// R17 - Port bases repeat every 0x20 entries
// R18 - Whole word snapshot taken at trigger
`include "mibcr_regs.svh"

module mibcr_counter_readout #(
	parameter int PORTS   = `MIBCR_PORTS,
	parameter int NCNT    = `MIBCR_CNT_PER_PORT,
	parameter int CNT_W   = `MIBCR_CNT_MSB + 1,
	parameter int DROP_W  = `MIBCR_DROP_MSB + 1
) (
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  reset,
	// Management register port
	input  wire logic                  regWrite,
	input  wire logic                  regRead,
	input  wire logic [7:0]            regAddr,
	input  wire logic [7:0]            regWrData,
	output logic      [7:0]            regRdData,
	output logic                       regRdValid,
	// Counting events from the frame datapaths
	input  wire logic [PORTS*NCNT-1:0] statEvent,
	input  wire logic [PORTS-1:0]      txDropEvent,
	input  wire logic [PORTS-1:0]      rxDropEvent
);
	localparam int NSTAT = PORTS * NCNT;
	localparam int NDROP = 2 * PORTS;

	// Counter storage
	logic [CNT_W-1:0]  statCount_q [NSTAT]; // R6
	logic [NSTAT-1:0]  statOvf_q;
	logic [NSTAT-1:0]  statValid_q;
	logic [DROP_W-1:0] dropCount_q [NDROP];

	// Indirect access state
	logic [7:0]        tableSel_q;
	logic [31:0]       result_q;
	logic [7:0]        regRdData_q;
	logic              regRdValid_q;
	mibcr_pkg::mibcr_src_t src_q;

	// Offset to statistics index; every port window starts on its own 0x20 base
	function automatic int statIndex(input logic [8:0] off);
		int o;
		int s;
		int x;
		o = int'(off);
		s = int'(`MIBCR_PORT_STRIDE);
		x = NCNT - s;
		// Ordinary window: port base plus counter offset
		if (o < PORTS * s && o % s < NCNT)
			return (o / s) * NCNT + o % s;
		// Entries past a window are packed after the last port, a group per port,
		// so no port base is ever shadowed by its neighbour
		if (x > 0 && o < PORTS * s + PORTS * x)
			return ((o - PORTS * s) / x) * NCNT + s + (o - PORTS * s) % x;
		return -1;
	endfunction

	// Trigger decode
	wire        trigWr    = regWrite && regAddr == `MIBCR_REG_TRIGGER;
	wire [8:0]  trigOff   = {tableSel_q == `MIBCR_TBL_DROPPED, regWrData};
	wire        selPort   = tableSel_q == `MIBCR_TBL_PORT_STAT; // R7
	wire        selDrop   = tableSel_q == `MIBCR_TBL_DROPPED; // R13
	int         statIdx;
	assign statIdx = statIndex({1'b0, regWrData}); // R9 R17
	wire        statHit   = trigWr && selPort && statIdx >= 0; // R8
	wire        dropHit   = trigWr && selDrop && trigOff <= `MIBCR_DROP_LAST;
	wire [3:0]  dropIdx   = 4'(trigOff - `MIBCR_DROP_TX_BASE); // R2 R3

	// Snapshot words
	wire [31:0] statWord  = statHit ? {statOvf_q[statIdx], statValid_q[statIdx],
		statCount_q[statIdx]} : `MIBCR_WORD_RESET; // R1
	wire [31:0] dropWord  = {16'h0000, dropCount_q[dropIdx]}; // R4 R5

	// Read data byte select, most significant byte first
	wire [7:0]  rdByte    = regAddr == `MIBCR_REG_DATA_B3 ? result_q[31:24] :
	                        regAddr == `MIBCR_REG_DATA_B2 ? result_q[23:16] :
	                        regAddr == `MIBCR_REG_DATA_B1 ? result_q[15:8]  :
	                        regAddr == `MIBCR_REG_DATA_B0 ? result_q[7:0]   :
	                        regAddr == `MIBCR_REG_TABLE_SEL ? tableSel_q : 8'h00; // R10

	// Per-port counters; a read clears, but an event in the same cycle still counts
	for (genvar g = 0; g < NSTAT; g++) begin : gStat
		wire clr = statHit && statIdx == g; // R14
		always_ff @(posedge clk or posedge reset) begin
			if (reset) begin
				statCount_q[g] <= '0;
				statOvf_q[g]   <= 1'b0;
				statValid_q[g] <= 1'b0;
			end else if (clr) begin
				statCount_q[g] <= CNT_W'(statEvent[g]);
				statOvf_q[g]   <= 1'b0;
				statValid_q[g] <= 1'b1;
			end else begin
				statValid_q[g] <= 1'b1;
				if (statEvent[g]) begin
					statCount_q[g] <= statCount_q[g] + 1'b1;
					if (&statCount_q[g])
						statOvf_q[g] <= 1'b1;
				end
			end
		end
	end

	// Dropped-frame counters never clear on read and wrap silently
	for (genvar d = 0; d < NDROP; d++) begin : gDrop
		wire ev = d < PORTS ? txDropEvent[d % PORTS] : rxDropEvent[d % PORTS];
		always_ff @(posedge clk or posedge reset) begin
			if (reset)
				dropCount_q[d] <= '0;
			else if (ev)
				dropCount_q[d] <= dropCount_q[d] + 1'b1; // R15
		end
	end

	// Table select register
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			tableSel_q <= 8'h00;
		else if (regWrite && regAddr == `MIBCR_REG_TABLE_SEL)
			tableSel_q <= regWrData; // R7
	end

	// Result snapshot taken in the trigger cycle so later byte reads agree
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			result_q <= `MIBCR_WORD_RESET;
			src_q    <= mibcr_pkg::MIBCR_SRC_NONE;
		end else if (statHit) begin
			result_q <= statWord; // R18
			src_q    <= mibcr_pkg::MIBCR_SRC_PORT;
		end else if (dropHit) begin
			result_q <= dropWord; // R13
			src_q    <= mibcr_pkg::MIBCR_SRC_DROP;
		end else if (trigWr) begin
			result_q <= `MIBCR_WORD_RESET;
			src_q    <= mibcr_pkg::MIBCR_SRC_NONE;
		end
	end

	// Registered read answer, one cycle after the strobe
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			regRdData_q  <= 8'h00;
			regRdValid_q <= 1'b0;
		end else begin
			regRdValid_q <= regRead;
			if (regRead)
				regRdData_q <= rdByte;
		end
	end

	assign regRdData  = regRdData_q;
	assign regRdValid = regRdValid_q;

	// A per-port trigger clears the selected counter on the next edge
	AST_READ_CLEARS: assert property (@(posedge clk) disable iff (reset) // R14
		statHit && !statEvent[statIdx] |=> statCount_q[$past(statIdx)] == '0)
		else $error("per-port counter not cleared by read");

	// Overflow flag starts over with the cleared count
	AST_OVF_CLEARS: assert property (@(posedge clk) disable iff (reset) // R14
		statHit |=> !statOvf_q[$past(statIdx)])
		else $error("overflow flag not cleared by read");

	// An event outside a read adds exactly one
	AST_STAT_COUNTS: assert property (@(posedge clk) disable iff (reset) // R6
		statEvent[14] && !(statHit && statIdx == 14) |=> statCount_q[14] == $past(statCount_q[14]) + 1'b1)
		else $error("per-port counter missed an event");

	// Once set after reset the valid flag never drops
	AST_VALID_STAYS: assert property (@(posedge clk) disable iff (reset) // R1
		statValid_q[0] |=> statValid_q[0])
		else $error("valid flag dropped");

	// A drop trigger leaves the selected counter unchanged or one higher, wrap included
	AST_DROP_KEEPS: assert property (@(posedge clk) disable iff (reset) // R15
		dropHit |=> DROP_W'(dropCount_q[$past(dropIdx)] - $past(dropCount_q[dropIdx])) <= DROP_W'(1))
		else $error("drop counter changed by read");

	// Transmit drop events add one, no flag involved
	AST_TX_DROP_COUNTS: assert property (@(posedge clk) disable iff (reset) // R2
		txDropEvent[0] |=> dropCount_q[0] == $past(dropCount_q[0]) + 1'b1)
		else $error("tx drop counter missed an event");

	// Receive drop events of the last port land in the last slot
	AST_RX_DROP_COUNTS: assert property (@(posedge clk) disable iff (reset) // R3
		rxDropEvent[PORTS-1] |=> dropCount_q[NDROP-1] == $past(dropCount_q[NDROP-1]) + 1'b1)
		else $error("rx drop counter missed an event");

	// Snapshot holds the selected word after the trigger
	AST_SNAPSHOT: assert property (@(posedge clk) disable iff (reset) // R18
		statHit |=> result_q == $past(statWord))
		else $error("snapshot mismatch");

	// Drop snapshot carries the selected count
	AST_DROP_SNAPSHOT: assert property (@(posedge clk) disable iff (reset) // R13
		dropHit |=> result_q[`MIBCR_DROP_MSB:0] == $past(dropCount_q[dropIdx]))
		else $error("drop snapshot mismatch");

	// Drop snapshots keep reserved and flag bits zero
	AST_DROP_UPPER: assert property (@(posedge clk) disable iff (reset) // R4
		src_q == mibcr_pkg::MIBCR_SRC_DROP |-> result_q[31:16] == 16'h0000)
		else $error("drop word upper bits set");

	// Unknown table or offset loads an empty word
	AST_BAD_TRIGGER_ZERO: assert property (@(posedge clk) disable iff (reset) // R8
		trigWr && !statHit && !dropHit |=> result_q == `MIBCR_WORD_RESET)
		else $error("refused trigger left data");

	// Only a trigger may change the snapshot
	AST_RESULT_HOLDS: assert property (@(posedge clk) disable iff (reset) // R18
		!trigWr |=> $stable(result_q))
		else $error("snapshot changed without trigger");

	// Byte 117 read returns the top byte one cycle later
	AST_MSB_FIRST: assert property (@(posedge clk) disable iff (reset) // R10
		regRead && regAddr == `MIBCR_REG_DATA_B3 && !trigWr |=> regRdValid && regRdData == result_q[31:24])
		else $error("byte 117 wrong");

	// Second byte from register 118
	AST_BYTE_118: assert property (@(posedge clk) disable iff (reset) // R10
		regRead && regAddr == `MIBCR_REG_DATA_B2 && !trigWr |=> regRdData == result_q[23:16])
		else $error("byte 118 wrong");

	// Third byte from register 119
	AST_BYTE_119: assert property (@(posedge clk) disable iff (reset) // R10
		regRead && regAddr == `MIBCR_REG_DATA_B1 && !trigWr |=> regRdData == result_q[15:8])
		else $error("byte 119 wrong");

	// Low byte from register 120
	AST_LSB_LAST: assert property (@(posedge clk) disable iff (reset) // R10
		regRead && regAddr == `MIBCR_REG_DATA_B0 && !trigWr |=> regRdData == result_q[7:0])
		else $error("byte 120 wrong");

	// Read answer is a single pulse exactly one cycle after the strobe
	AST_RD_VALID_PULSE: assert property (@(posedge clk) disable iff (reset) // R10
		regRdValid == $past(regRead))
		else $error("read answer timing wrong");

	// Read data stands until the next read
	AST_RD_HOLDS: assert property (@(posedge clk) disable iff (reset) // R10
		!regRead |=> $stable(regRdData))
		else $error("read data changed without read");

	// Registers outside the readout answer zero
	AST_UNMAPPED_ZERO: assert property (@(posedge clk) disable iff (reset) // R10
		regRead && regAddr != `MIBCR_REG_TABLE_SEL
		&& (regAddr < `MIBCR_REG_DATA_B3 || regAddr > `MIBCR_REG_DATA_B0) |=> regRdData == 8'h00)
		else $error("unmapped read not zero");

	// Table select follows a write to register 110
	AST_TABLE_SEL: assert property (@(posedge clk) disable iff (reset) // R7
		regWrite && regAddr == `MIBCR_REG_TABLE_SEL |=> tableSel_q == $past(regWrData))
		else $error("table select not stored");

	// Table select changes only on its own write
	AST_SEL_HOLDS: assert property (@(posedge clk) disable iff (reset) // R7
		!(regWrite && regAddr == `MIBCR_REG_TABLE_SEL) |=> $stable(tableSel_q))
		else $error("table select changed unasked");

	// Trigger with port table marks a per-port snapshot
	AST_PORT_SRC: assert property (@(posedge clk) disable iff (reset) // R1
		statHit |=> src_q == mibcr_pkg::MIBCR_SRC_PORT ##1 result_q[`MIBCR_BIT_VALID]
		|| src_q != mibcr_pkg::MIBCR_SRC_PORT || $past(trigWr))
		else $error("per-port snapshot lost");

	// Port one minimum-length frame counter sits at offset 0x0e
	AST_PORT_ONE_BASE: assert property (@(posedge clk) disable iff (reset) // R8
		trigWr && selPort && regWrData == 8'h0e |-> statIdx == 14)
		else $error("port one decode wrong");

	// Port two window starts at 0x20
	AST_PORT_TWO_BASE: assert property (@(posedge clk) disable iff (reset) // R17
		trigWr && selPort && regWrData == 8'h20 |-> statIdx == NCNT)
		else $error("port two base decode wrong");

	// Port two minimum-length frame counter maps to index NCNT+14
	AST_PORT_BASE: assert property (@(posedge clk) disable iff (reset) // R9
		trigWr && selPort && regWrData == 8'h2e |-> statIdx == NCNT + 14)
		else $error("port base decode wrong");

	// Last packed offset reaches the last counter of the last port
	AST_EXTRA_MAP: assert property (@(posedge clk) disable iff (reset) // R6
		trigWr && selPort && regWrData == 8'ha9 |-> statIdx == NSTAT - 1)
		else $error("packed counter decode wrong");
endmodule

// file: mibcr_host_model.sv
// Purpose: host side of the byte-wide management register port
// Assumes: requests launched 1 ns after the rising edge
// Notes:   released write data is inverted so stale bytes never look valid
`include "mibcr_regs.svh"

module mibcr_host_model (
	// Clock
	input  wire logic       clk,
	// Register port towards the device
	output logic            regWrite,
	output logic            regRead,
	output logic      [7:0] regAddr,
	output logic      [7:0] regWrData,
	input  wire logic [7:0] regRdData,
	input  wire logic       regRdValid
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle bus at time zero
	initial begin
		regWrite = 1'b0;
		regRead = 1'b0;
		regAddr = 8'h00;
		regWrData = 8'h00;
	end
	// One write cycle, table select or trigger
	task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) #1;
		regWrite = 1'b1;
		regAddr = a;
		regWrData = d;
		@(posedge clk) #1;
		regWrite = 1'b0;
		regWrData = ~d;
	endtask
	// One read cycle, answer one cycle later
	task automatic rdReg(input logic [7:0] a, output logic [7:0] d);
		int n;
		@(posedge clk) #1;
		regRead = 1'b1;
		regAddr = a;
		@(posedge clk) #1;
		regRead = 1'b0;
		n = 0;
		while (regRdValid !== 1'b1 && n < 4) begin
			@(posedge clk) #1;
			n++;
		end
		// A late answer poisons the byte so the compare trips
		d = (n == 0) ? regRdData : 8'hxx;
	endtask
	// Whole word high byte first; restart while not yet valid
	task automatic rdWord(output logic [31:0] w);
		int k;
		rdReg(`MIBCR_REG_DATA_B3, w[31:24]);
		k = 0;
		while (w[`MIBCR_BIT_VALID] !== 1'b1 && k < 4) begin
			rdReg(`MIBCR_REG_DATA_B3, w[31:24]);
			k++;
		end
		rdReg(`MIBCR_REG_DATA_B2, w[23:16]);
		rdReg(`MIBCR_REG_DATA_B1, w[15:8]);
		rdReg(`MIBCR_REG_DATA_B0, w[7:0]);
	endtask
	// Dropped-frame count, low two bytes only; wrap is the host's job
	task automatic rdDrop(output logic [15:0] v);
		rdReg(`MIBCR_REG_DATA_B1, v[15:8]);
		rdReg(`MIBCR_REG_DATA_B0, v[7:0]);
	endtask
endmodule

// file: test_mib_counter_indirect_readout.sv
// Purpose: self-checking bench of the statistics readout
// Assumes: host model drives the register port, bench drives events
// Notes:   expected words built from field positions, never from outputs
`include "mibcr_regs.svh"

module test_mib_counter_indirect_readout;
	timeunit 1ns;
	timeprecision 1ns;
	// Stimulus and observation
	logic         clk;
	logic         reset;
	logic         regWrite;
	logic         regRead;
	logic [7:0]   regAddr;
	logic [7:0]   regWrData;
	logic [7:0]   regRdData;
	logic         regRdValid;
	logic [169:0] statEvent;
	logic [4:0]   txDropEvent;
	logic [4:0]   rxDropEvent;
	logic [31:0]  w;
	logic [15:0]  h;
	logic [7:0]   b;
	int           fails;
	int           num_checks;
	int           cycles;
	// Clock
	always #25 clk = ~clk;
	// Design and host
	mibcr_counter_readout u_mibcr_counter_readout (.clk(clk), .reset(reset),
		.regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData),
		.regRdData(regRdData), .regRdValid(regRdValid), .statEvent(statEvent),
		.txDropEvent(txDropEvent), .rxDropEvent(rxDropEvent));
	mibcr_host_model u_mibcr_host_model (.clk(clk), .regWrite(regWrite), .regRead(regRead),
		.regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
		.regRdValid(regRdValid));
	// Compare and report
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// Separate pulses, one event each; sel 0 stat, 1 tx drop, 2 rx drop
	task automatic pulse(input int sel, input int idx, input int n);
		repeat (n) begin
			@(posedge clk) #1;
			if (sel == 0) statEvent[idx] = 1'b1;
			else if (sel == 1) txDropEvent[idx] = 1'b1;
			else rxDropEvent[idx] = 1'b1;
			@(posedge clk) #1;
			statEvent = '0;
			txDropEvent = '0;
			rxDropEvent = '0;
		end
	endtask
	// Hang guard, tests need well under a thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles > 3000) begin
			fails++;
			complete_run();
		end
	end
	// Main sequence
	initial begin
		clk = 1'b0;
		reset = 1'b1;
		statEvent = '0;
		txDropEvent = '0;
		rxDropEvent = '0;
		repeat (2) @(posedge clk);
		#1 reset = 1'b0;
		pulse(0, 14, 3);
		u_mibcr_host_model.wrReg(`MIBCR_REG_TABLE_SEL, `MIBCR_TBL_PORT_STAT);
		u_mibcr_host_model.wrReg(`MIBCR_REG_TRIGGER, 8'h0e);
		u_mibcr_host_model.rdWord(w);
		check("port1 min frame", w, {2'b01, 30'd3});
		u_mibcr_host_model.wrReg(`MIBCR_REG_TRIGGER, 8'h0e);
		u_mibcr_host_model.rdWord(w);
		check("port1 after clear", w, {2'b01, 30'd0});
		pulse(0, 48, 1);
		u_mibcr_host_model.wrReg(`MIBCR_REG_TRIGGER, 8'h2e);
		u_mibcr_host_model.rdWord(w);
		check("port2 min frame", w, {2'b01, 30'd1});
		pulse(0, 34, 1);
		u_mibcr_host_model.wrReg(`MIBCR_REG_TRIGGER, 8'h20);
		u_mibcr_host_model.rdWord(w);
		check("port2 base", w, {2'b01, 30'd1});
		pulse(0, 169, 2);
		u_mibcr_host_model.wrReg(`MIBCR_REG_TRIGGER, 8'ha9);
		u_mibcr_host_model.rdWord(w);
		check("port5 last counter", w, {2'b01, 30'd2});
		u_mibcr_host_model.wrReg(`MIBCR_REG_TRIGGER, 8'hc0);
		u_mibcr_host_model.rdWord(w);
		check("port offset out of range", w, 32'h0000_0000);
		$display("test port counters done");
		pulse(1, 0, 2);
		pulse(2, 4, 1);
		u_mibcr_host_model.wrReg(`MIBCR_REG_TABLE_SEL, `MIBCR_TBL_DROPPED);
		u_mibcr_host_model.wrReg(`MIBCR_REG_TRIGGER, 8'h00);
		u_mibcr_host_model.rdDrop(h);
		check("tx drop port1", {16'h0000, h}, 32'h0000_0002);
		u_mibcr_host_model.wrReg(`MIBCR_REG_TRIGGER, 8'h00);
		u_mibcr_host_model.rdDrop(h);
		check("tx drop reread", {16'h0000, h}, 32'h0000_0002);
		u_mibcr_host_model.wrReg(`MIBCR_REG_TRIGGER, 8'h09);
		u_mibcr_host_model.rdDrop(h);
		check("rx drop port5", {16'h0000, h}, 32'h0000_0001);
		u_mibcr_host_model.wrReg(`MIBCR_REG_TRIGGER, 8'h0a);
		u_mibcr_host_model.rdDrop(h);
		check("drop offset out of range", {16'h0000, h}, 32'h0000_0000);
		u_mibcr_host_model.rdReg(`MIBCR_REG_TABLE_SEL, b);
		check("table select", {24'h0000_00, b}, 32'h0000_001d);
		u_mibcr_host_model.rdReg(8'd50, b);
		check("unmapped read", {24'h0000_00, b}, 32'h0000_0000);
		$display("test drop counters done");
		complete_run();
	end
endmodule
